// [rtl/fica_bridge.sv]
// Indirect fabric register access bridge with per-port flow control enables.
`timescale 1ns/1ns
`default_nettype none
module fica_bridge #(
    parameter logic [15:0] WIN_FAB_BASE = 16'h0000
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // AXI4-Lite slave
    input wire logic [fica_pkg::AXI_AW-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [fica_pkg::AXI_AW-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Fabric register port
    output logic fab_req,
    output logic fab_we,
    output logic [15:0] fab_addr,
    output logic [3:0] fab_be,
    output logic [31:0] fab_wdata,
    input wire logic fab_ack,
    input wire logic [31:0] fab_rdata,
    // Per-port link status
    input wire logic [fica_pkg::PORTS-1:0] port_full_duplex,
    input wire logic [fica_pkg::PORTS-1:0] port_an_enable,
    input wire logic [fica_pkg::PORTS-1:0] port_an_complete,
    input wire logic [fica_pkg::PORTS-1:0] port_lp_an_able,
    input wire logic [fica_pkg::PORTS-1:0] port_adv_pause,
    input wire logic [fica_pkg::PORTS-1:0] port_adv_asym,
    input wire logic [fica_pkg::PORTS-1:0] port_lp_pause,
    input wire logic [fica_pkg::PORTS-1:0] port_lp_asym,
    // Per-port flow control enables
    output logic [fica_pkg::PORTS-1:0] port_tx_fc_en,
    output logic [fica_pkg::PORTS-1:0] port_rx_fc_en
);
    fica_pkg::fica_state_s q, d;
    logic wr_fire;
    logic rd_fire;
    logic idle;
    logic [11:0] wa;
    logic [11:0] ra;
    logic [31:0] wmask;
    logic w_data, w_cmd, w_win;
    logic [31:0] cmd_rd;
    logic [31:0] cmd_new;
    logic [15:0] addr_stepped;
    logic [fica_pkg::PORTS-1:0] tx_res;
    logic [fica_pkg::PORTS-1:0] rx_res;

    assign wr_fire = s_axi_awvalid & s_axi_wvalid & ~q.bvalid;
    assign rd_fire = s_axi_arvalid & ~q.rvalid;
    assign s_axi_awready = wr_fire;
    assign s_axi_wready = wr_fire;
    assign s_axi_arready = ~q.rvalid;
    assign idle = (q.st == fica_pkg::ST_IDLE);
    assign wa = {s_axi_awaddr[11:2], 2'h0};
    assign ra = {s_axi_araddr[11:2], 2'h0};
    assign wmask = {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}},
                    {8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};
    assign w_data = wr_fire & (wa == fica_pkg::OFS_DATA);
    assign w_cmd = wr_fire & (wa == fica_pkg::OFS_CMD);
    assign w_win = wr_fire & ((wa & fica_pkg::WIN_MASK) == fica_pkg::OFS_WIN);
    assign cmd_rd = {~idle, q.rnw, q.inc, q.dec, 8'h00, q.be, q.addr};
    assign cmd_new = (cmd_rd & ~wmask) | (s_axi_wdata & wmask);
    // Decrement wins only when increment is clear; both set steps up.
    assign addr_stepped = q.inc ? q.addr + fica_pkg::ADDR_STEP : q.addr - fica_pkg::ADDR_STEP;

    // Flow control resolution; advertisement bits are inputs only, never written here.
    for (genvar p = 0; p < fica_pkg::PORTS; p++)
    begin : g_fc
        logic man, sym;
        assign man = q.fc[p][fica_pkg::FC_MAN] | ~port_an_enable[p];
        assign sym = port_adv_pause[p] & port_lp_pause[p];
        assign tx_res[p] = man ? (port_full_duplex[p] ? q.fc[p][fica_pkg::FC_TX]
                                                      : q.fc[p][fica_pkg::FC_BP])
            : ~port_an_complete[p] ? 1'b0
            : (~port_lp_an_able[p] | ~port_full_duplex[p]) ? q.fc[p][fica_pkg::FC_BP]
            : sym | (~port_adv_pause[p] & port_adv_asym[p] & port_lp_pause[p]
                     & port_lp_asym[p]);
        assign rx_res[p] = man ? (port_full_duplex[p] & q.fc[p][fica_pkg::FC_RX])
            : (~port_an_complete[p] | ~port_lp_an_able[p] | ~port_full_duplex[p]) ? 1'b0
            : sym | (port_adv_pause[p] & port_adv_asym[p] & ~port_lp_pause[p]
                     & port_lp_asym[p]);
    end

    always_comb
    begin
        d = q;
        d.tx_en = tx_res;
        d.rx_en = rx_res;
        if (q.bvalid && s_axi_bready)
            d.bvalid = 1'b0;
        if (q.rvalid && s_axi_rready)
            d.rvalid = 1'b0;
        // Accesses that would start a cycle are dropped while busy, so the
        // fabric never sees an address or data change under a request.
        if (wr_fire)
        begin
            d.bvalid = 1'b1;
            d.bresp = fica_pkg::RESP_OKAY;
            if (w_data)
            begin
                if (idle)
                begin
                    d.data = (q.data & ~wmask) | (s_axi_wdata & wmask);
                    if ((q.inc || q.dec) && !q.rnw)
                        d.st = fica_pkg::ST_FABRIC;
                end
            end
            else if (w_cmd)
            begin
                if (idle)
                begin
                    d.rnw = cmd_new[fica_pkg::CMD_RNW];
                    d.inc = cmd_new[fica_pkg::CMD_INC];
                    d.dec = cmd_new[fica_pkg::CMD_DEC];
                    d.be = cmd_new[fica_pkg::CMD_BE_LO +: 4];
                    d.addr = cmd_new[15:0];
                    if (cmd_new[fica_pkg::CMD_BUSY])
                        d.st = fica_pkg::ST_FABRIC;
                end
            end
            else if (w_win)
            begin
                if (idle)
                begin
                    d.data = (q.data & ~wmask) | (s_axi_wdata & wmask);
                    d.addr = WIN_FAB_BASE
                        + 16'(s_axi_awaddr[fica_pkg::WIN_LSB +: fica_pkg::WIN_IW]);
                    d.be = fica_pkg::BE_ALL;
                    d.rnw = 1'b0;
                    d.st = fica_pkg::ST_FABRIC;
                end
            end
            else
            begin
                d.bresp = fica_pkg::RESP_SLVERR;
                for (int i = 0; i < fica_pkg::PORTS; i++)
                begin
                    if (wa == fica_pkg::OFS_FC0 + 12'(i) * fica_pkg::OFS_FC_STEP)
                    begin
                        d.bresp = fica_pkg::RESP_OKAY;
                        if (s_axi_wstrb[0])
                            d.fc[i] = s_axi_wdata[3:0];
                    end
                end
            end
        end
        if (rd_fire)
        begin
            d.rvalid = 1'b1;
            d.rresp = fica_pkg::RESP_OKAY;
            d.rdata = 32'h0000_0000;
            if (ra == fica_pkg::OFS_DATA)
            begin
                d.rdata = q.data;
                if (idle && q.rnw && (q.inc || q.dec))
                begin
                    d.addr = addr_stepped;
                    d.st = fica_pkg::ST_FABRIC;
                end
            end
            else if (ra == fica_pkg::OFS_CMD)
                d.rdata = cmd_rd;
            else if ((ra & fica_pkg::WIN_MASK) == fica_pkg::OFS_WIN)
                d.rdata = 32'h0000_0000;
            else
            begin
                d.rresp = fica_pkg::RESP_SLVERR;
                for (int i = 0; i < fica_pkg::PORTS; i++)
                begin
                    if (ra == fica_pkg::OFS_FC0 + 12'(i) * fica_pkg::OFS_FC_STEP)
                    begin
                        d.rresp = fica_pkg::RESP_OKAY;
                        d.rdata = {28'h0000_000, q.fc[i]};
                    end
                end
            end
        end
        if (!idle && fab_ack)
        begin
            d.st = fica_pkg::ST_IDLE;
            if (q.rnw)
                d.data = fab_rdata;
            else if (q.inc || q.dec)
                d.addr = addr_stepped;
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            q.st <= fica_pkg::ST_IDLE;
            q.data <= fica_pkg::DATA_RST;
            q.rnw <= 1'b0;
            q.inc <= 1'b0;
            q.dec <= 1'b0;
            q.be <= fica_pkg::BE_RST;
            q.addr <= fica_pkg::ADDR_RST;
            q.fc <= {fica_pkg::PORTS{fica_pkg::FC_RST}};
            q.bvalid <= 1'b0;
            q.bresp <= fica_pkg::RESP_OKAY;
            q.rvalid <= 1'b0;
            q.rdata <= 32'h0000_0000;
            q.rresp <= fica_pkg::RESP_OKAY;
            q.tx_en <= '0;
            q.rx_en <= '0;
        end
        else
            q <= d;
    end

    assign s_axi_bvalid = q.bvalid;
    assign s_axi_bresp = q.bresp;
    assign s_axi_rvalid = q.rvalid;
    assign s_axi_rdata = q.rdata;
    assign s_axi_rresp = q.rresp;
    assign fab_req = ~idle;
    assign fab_we = ~q.rnw;
    assign fab_addr = q.addr;
    assign fab_be = q.be;
    assign fab_wdata = q.data;
    assign port_tx_fc_en = q.tx_en;
    assign port_rx_fc_en = q.rx_en;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    property p_cmd_start;
        (w_cmd && idle && s_axi_wstrb[3] && s_axi_wdata[fica_pkg::CMD_BUSY])
            |=> fab_req && (fab_we == !$past(s_axi_wdata[fica_pkg::CMD_RNW]));
    endproperty
    a_cmd_start: assert property (p_cmd_start) else $error("command did not start");

    property p_done_clears;
        (fab_req && fab_ack) |=> !fab_req ##1 !fab_req || $past(wr_fire || rd_fire);
    endproperty
    a_done_clears: assert property (p_done_clears) else $error("busy not cleared");

    property p_read_load;
        (fab_req && fab_ack && !fab_we) |=> !fab_req && (fab_wdata == $past(fab_rdata));
    endproperty
    a_read_load: assert property (p_read_load) else $error("read data not loaded");

    property p_wr_step;
        (fab_req && fab_ack && fab_we && q.inc)
            |=> (fab_addr == $past(fab_addr) + fica_pkg::ADDR_STEP) && !fab_req;
    endproperty
    a_wr_step: assert property (p_wr_step) else $error("address not stepped");

    property p_win;
        (w_win && idle) |=> fab_req && fab_we && (fab_be == fica_pkg::BE_ALL);
    endproperty
    a_win: assert property (p_win) else $error("window write not started");

    property p_data_auto_wr;
        (w_data && idle && (q.inc || q.dec) && !q.rnw) |=> fab_req && fab_we;
    endproperty
    a_data_auto_wr: assert property (p_data_auto_wr) else $error("auto write missed");

    property p_auto_rd;
        (rd_fire && ra == fica_pkg::OFS_DATA && idle && q.rnw && q.dec && !q.inc)
            |=> fab_req && (fab_addr == $past(fab_addr) - fica_pkg::ADDR_STEP);
    endproperty
    a_auto_rd: assert property (p_auto_rd) else $error("auto read missed");

    property p_half_manual;
        (!port_full_duplex[0] && (q.fc[0][fica_pkg::FC_MAN] || !port_an_enable[0]))
            |=> !port_rx_fc_en[0] && (port_tx_fc_en[0] == $past(q.fc[0][fica_pkg::FC_BP]));
    endproperty
    a_half_manual: assert property (p_half_manual) else $error("half duplex wrong");

    property p_an_pending;
        (port_an_enable[1] && !port_an_complete[1] && !q.fc[1][fica_pkg::FC_MAN])
            |=> !port_tx_fc_en[1] && !port_rx_fc_en[1];
    endproperty
    a_an_pending: assert property (p_an_pending) else $error("enables on during AN");

    property p_req_hold;
        (fab_req && !fab_ack) |=> fab_req && $stable(fab_addr) && $stable(fab_wdata);
    endproperty
    a_req_hold: assert property (p_req_hold) else $error("request changed while busy");

    c_single_write: cover property (w_cmd && idle ##1 fab_req && fab_we ##[1:20] fab_ack);
    c_auto_read: cover property (rd_fire && ra == fica_pkg::OFS_DATA && idle && q.inc);
    c_window: cover property (w_win && idle ##[1:20] fab_ack);
endmodule
`default_nettype wire

// [rtl/fica_pkg.sv]
// Constants and state types shared by the fabric register bridge.
package fica_pkg;
    localparam int AXI_AW = 12;
    localparam int PORTS = 3;
    // Register byte offsets.
    localparam logic [11:0] OFS_DATA = 12'h000;
    localparam logic [11:0] OFS_CMD = 12'h004;
    localparam logic [11:0] OFS_FC0 = 12'h010;
    localparam logic [11:0] OFS_FC_STEP = 12'h004;
    localparam logic [11:0] OFS_WIN = 12'h200;
    localparam logic [11:0] WIN_MASK = 12'he00;
    localparam int WIN_IW = 7;
    localparam int WIN_LSB = 2;
    // Command register fields.
    localparam int CMD_BUSY = 31;
    localparam int CMD_RNW = 30;
    localparam int CMD_INC = 29;
    localparam int CMD_DEC = 28;
    localparam int CMD_BE_LO = 16;
    localparam logic [3:0] BE_ALL = 4'hf;
    localparam logic [15:0] ADDR_STEP = 16'h0001;
    // Manual flow control register fields.
    localparam int FC_BP = 0;
    localparam int FC_RX = 1;
    localparam int FC_TX = 2;
    localparam int FC_MAN = 3;
    localparam logic [3:0] FC_RST = 4'h0;
    localparam logic [31:0] DATA_RST = 32'h0000_0000;
    localparam logic [15:0] ADDR_RST = 16'h0000;
    localparam logic [3:0] BE_RST = 4'h0;
    // Bus responses.
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [0:0] {ST_IDLE, ST_FABRIC} fica_fsm_e;

    typedef struct packed {
        fica_fsm_e st;
        logic [31:0] data;
        logic rnw;
        logic inc;
        logic dec;
        logic [3:0] be;
        logic [15:0] addr;
        logic [PORTS-1:0][3:0] fc;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic [PORTS-1:0] tx_en;
        logic [PORTS-1:0] rx_en;
    } fica_state_s;
endpackage

// [test/fica_fab_model.sv]
// Behavioural model of the fabric register space behind the bridge.
`timescale 1ns/1ns
`default_nettype none
module fica_fab_model (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Fabric port
    input wire logic fab_req,
    input wire logic fab_we,
    input wire logic [15:0] fab_addr,
    input wire logic [3:0] fab_be,
    input wire logic [31:0] fab_wdata,
    output logic fab_ack,
    output logic [31:0] fab_rdata,
    // Answer delay in cycles
    input wire logic [3:0] dly
);
    logic [31:0] mem [64];
    logic [31:0] rd_q;
    logic [3:0] cnt;
    logic done;
    // Outside the answer cycle the data lines show garbage, so a stale word never looks valid.
    assign fab_rdata = fab_ack ? rd_q : ~rd_q;
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            for (int i = 0; i < 64; i++)
                mem[i] <= 32'h0;
            rd_q <= 32'h0;
            cnt <= 4'h0;
            done <= 1'b0;
            fab_ack <= 1'b0;
        end
        else
        begin
            fab_ack <= 1'b0;
            if (!fab_req)
            begin
                cnt <= 4'h0;
                done <= 1'b0;
            end
            else if (!done && cnt == dly)
            begin
                fab_ack <= 1'b1;
                done <= 1'b1;
                rd_q <= mem[fab_addr[5:0]];
                for (int b = 0; b < 4; b++)
                    if (fab_we && fab_be[b])
                        mem[fab_addr[5:0]][8*b+:8] <= fab_wdata[8*b+:8];
            end
            else if (!done)
                cnt <= cnt + 4'h1;
        end
    end
endmodule
`default_nettype wire

// [test/tb_fabric_indirect_csr_access.sv]
// Self-checking bench for the fabric register bridge and its flow control enables.
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin fails++; \
    $display("[ERR] %0t got %h exp %h", $time, (g), (e)); end end
module tb_fabric_indirect_csr_access;
    localparam logic [15:0] WB = 16'h0010;
    localparam logic [11:0] OD = fica_pkg::OFS_DATA;
    localparam logic [11:0] OC = fica_pkg::OFS_CMD;
    localparam logic [31:0] BSY = 32'h1 << fica_pkg::CMD_BUSY;
    localparam logic [31:0] RNW = 32'h1 << fica_pkg::CMD_RNW;
    localparam logic [31:0] INC = 32'h1 << fica_pkg::CMD_INC;
    localparam logic [31:0] DEC = 32'h1 << fica_pkg::CMD_DEC;
    logic clk = 1'b0, rst_n = 1'b0;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'hf, dly = 4'h0;
    logic [2:0] port_full_duplex = 3'h0, port_an_enable = 3'h0, port_an_complete = 3'h0;
    logic [2:0] port_lp_an_able = 3'h0, port_adv_pause = 3'h0, port_adv_asym = 3'h0;
    logic [2:0] port_lp_pause = 3'h0, port_lp_asym = 3'h0, port_tx_fc_en, port_rx_fc_en;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic fab_req, fab_we, fab_ack;
    logic [1:0] s_axi_bresp, s_axi_rresp, bresp, rrsp;
    logic [31:0] s_axi_rdata, fab_wdata, fab_rdata, rdv;
    logic [15:0] fab_addr;
    logic [3:0] fab_be;
    int fails = 0, comparisons = 0, p;
    // Duplex, negotiation status, local and partner pause, flow register, then tx and rx.
    logic [13:0] rows [17] = '{14'h1fee, 14'h0018, 14'h3fe9, 14'h200d, 14'h37dc, 14'h3bde,
        14'h1fc6, 14'h3cdc, 14'h3d5c, 14'h3d9c, 14'h3dde, 14'h3e5c, 14'h3e9f, 14'h3fdf,
        14'h3f1c, 14'h3f5d, 14'h3ff2};

    always #20 clk = ~clk;

    fica_bridge #(.WIN_FAB_BASE(WB)) u_dut (.clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .fab_req, .fab_we, .fab_addr, .fab_be, .fab_wdata, .fab_ack, .fab_rdata,
        .port_full_duplex, .port_an_enable, .port_an_complete, .port_lp_an_able,
        .port_adv_pause, .port_adv_asym, .port_lp_pause, .port_lp_asym,
        .port_tx_fc_en, .port_rx_fc_en);

    fica_fab_model u_fab (.clk, .rst_n, .fab_req, .fab_we, .fab_addr, .fab_be, .fab_wdata,
        .fab_ack, .fab_rdata, .dly);

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do @(posedge clk); while (!(s_axi_awready && s_axi_wready));
        s_axi_awvalid <= 1'b0;
        s_axi_wvalid <= 1'b0;
        do @(posedge clk); while (!s_axi_bvalid);
        bresp = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask

    task automatic rd(input logic [11:0] a);
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge clk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        do @(posedge clk); while (!s_axi_rvalid);
        rdv = s_axi_rdata;
        rrsp = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask

    // Software keeps off the bridge until the busy flag drops; the watchdog bounds a hang.
    task automatic poll();
        do rd(OC); while (rdv[fica_pkg::CMD_BUSY] !== 1'b0);
    endtask

    task automatic endt(input string s);
        $display("%s done", s);
    endtask

    task automatic aw_case(input logic [31:0] m, input logic [15:0] a0, a1, input logic [31:0] d);
        wr(OC, m | 32'h000f_0000 | {16'h0, a0});
        wr(OD, d);
        poll();
        `CHK(rdv[15:0], a1)
        `CHK(u_fab.mem[a0[5:0]], d)
    endtask

    task automatic print_verdict();
        $display("fails=%0d comparisons=%0d", fails, comparisons);
        if (fails == 0 && comparisons > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    initial
    begin
        #(40 * 20000);
        fails++;
        print_verdict();
    end

    initial
    begin
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        rd(OC);
        `CHK(rdv, 32'h0)
        rd(OD);
        `CHK(rdv, 32'h0)
        endt("reset");
        for (int i = 0; i < 17; i++)
        begin
            p = i % 3;
            port_full_duplex[p] <= rows[i][13];
            port_an_enable[p] <= rows[i][12];
            port_an_complete[p] <= rows[i][11];
            port_lp_an_able[p] <= rows[i][10];
            port_adv_pause[p] <= rows[i][9];
            port_adv_asym[p] <= rows[i][8];
            port_lp_pause[p] <= rows[i][7];
            port_lp_asym[p] <= rows[i][6];
            wr(fica_pkg::OFS_FC0 + 12'(p) * fica_pkg::OFS_FC_STEP, {28'h0, rows[i][5:2]});
            repeat (2) @(posedge clk);
            `CHK(port_tx_fc_en[p], rows[i][1])
            `CHK(port_rx_fc_en[p], rows[i][0])
        end
        endt("flow table");
        dly <= 4'h5;
        wr(OD, 32'h1234_5678);
        wr(OC, BSY | 32'h0003_0005);
        rd(OC);
        `CHK(rdv[fica_pkg::CMD_BUSY], 1'b1)
        poll();
        `CHK(u_fab.mem[5], 32'h0000_5678)
        wr(OC, BSY | RNW | 32'h5);
        poll();
        rd(OD);
        `CHK(rdv, 32'h0000_5678)
        wr(OC, BSY | 32'h000f_0006);
        wr(OD, 32'hdead_beef);
        poll();
        `CHK(u_fab.mem[6], 32'h0000_5678)
        rd(OD);
        `CHK(rdv, 32'h0000_5678)
        // Partial strobes must merge only the selected bytes into the data register.
        s_axi_wstrb <= 4'h3;
        wr(OD, 32'h1111_2222);
        s_axi_wstrb <= 4'hf;
        rd(OD);
        `CHK(rdv, 32'h0000_2222)
        endt("single");
        aw_case(INC, 16'h0008, 16'h0009, 32'ha5a5_0001);
        aw_case(DEC, 16'h0028, 16'h0027, 32'ha5a5_0002);
        aw_case(INC | DEC, 16'h001e, 16'h001f, 32'ha5a5_0003);
        wr(OC, BSY | RNW | INC | 32'h8);
        poll();
        rd(OD);
        `CHK(rdv, 32'ha5a5_0001)
        poll();
        `CHK(rdv[15:0], 16'h0009)
        wr(OC, RNW | 32'h9);
        rd(OD);
        `CHK(rdv, 32'h0)
        rd(OC);
        `CHK(rdv, RNW | 32'h9)
        wr(OC, BSY | RNW | DEC | 32'h28);
        poll();
        rd(OD);
        `CHK(rdv, 32'ha5a5_0002)
        poll();
        `CHK(rdv[15:0], 16'h0027)
        wr(OC, RNW | 32'h27);
        endt("auto step");
        wr(fica_pkg::OFS_WIN + 12'h00c, 32'hcafe_f00d);
        poll();
        `CHK(rdv, 32'h000f_0013)
        `CHK(u_fab.mem[19], 32'hcafe_f00d)
        wr(12'h400, 32'h1);
        `CHK(bresp, fica_pkg::RESP_SLVERR)
        rd(fica_pkg::OFS_WIN);
        `CHK(rdv, 32'h0)
        rd(12'h020);
        `CHK(rrsp, fica_pkg::RESP_SLVERR)
        endt("window");
        // A reset in the middle of a fabric cycle must drop busy and clear the command.
        wr(OC, BSY | 32'h000f_0001);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        `CHK(fab_req, 1'b0)
        rst_n <= 1'b1;
        rd(OC);
        `CHK(rdv, 32'h0)
        endt("mid reset");
        print_verdict();
    end
endmodule
`default_nettype wire
